// file: common/qpe_regs.svh
`ifndef QPE_REGS_SVH
`define QPE_REGS_SVH

// Command opcodes
`define QPE_OP_QPROG    8'h32
`define QPE_OP_ERASE4K  8'h20
`define QPE_OP_ERASE32K 8'h52
`define QPE_OP_ERASE64K 8'hD8

// Frame layout in link bits
`define QPE_OPC_BITS    6'h08
`define QPE_HDR_BITS    6'h20

// Page and erased value
`define QPE_PAGE_LAST   9'h0FF
`define QPE_PAGE_END    9'h100
`define QPE_BYTE_MAX    9'h100
`define QPE_ERASED      8'hFF

// Ignored low address bits per erase size
`define QPE_MASK_4K     24'h000FFF
`define QPE_MASK_32K    24'h007FFF
`define QPE_MASK_64K    24'h00FFFF

// Timing: core clock rate and self-timed durations
`define QPE_CLK_MHZ     40
`define QPE_PP_TIME_US  500
`define QPE_BE_TIME_US  2000

`endif

// file: common/qpe_pkg.sv
package qpe_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PROG  = 2'b01,
    ST_ERASE = 2'b10,
    ST_WAIT  = 2'b11
  } qpe_state_t;

  // Erase block size selected by opcode
  typedef enum logic [1:0] {
    SZ_4K  = 2'b00,
    SZ_32K = 2'b01,
    SZ_64K = 2'b10
  } qpe_size_t;

endpackage : qpe_pkg

// file: src/qpe_page_buf.sv
`timescale 1ns/1ps
// Page buffer, one write port, registered read port
module qpe_page_buf (
  input  wire logic       i_clk,
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_wr_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic [7:0] i_rd_addr,
  output logic      [7:0] o_rd_data
);

  logic [7:0] mem [0:255]; // One entry per page byte

  // No reset: contents are only read where a valid bit says so
  always_ff @(posedge i_clk)
  begin
    if (i_wr_en)
    begin
      mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem[i_rd_addr];
  end

endmodule : qpe_page_buf

// file: src/qpe_seq.sv
`timescale 1ns/1ps
`include "qpe_regs.svh"
module qpe_seq #(
  parameter int PP_CYCLES = `QPE_PP_TIME_US * `QPE_CLK_MHZ, // Page program time
  parameter int BE_CYCLES = `QPE_BE_TIME_US * `QPE_CLK_MHZ  // Block erase time
) (
  input  wire logic              I_CLK,
  input  wire logic              I_RSTN,
  input  wire logic              I_CS_N,
  input  wire logic              I_SCK,
  input  wire logic [3:0]        I_IO,
  input  wire logic              I_WRITE_ENABLE,
  input  wire logic              I_ADDR_PROTECTED,
  input  wire logic              I_VERIFY_FAIL,
  output logic                   O_BUSY,
  output logic                   O_WRITE_LATCH,
  output logic                   O_PE_ERROR,
  output logic [23:0]            O_CHECK_ADDR,
  output logic                   O_ARRAY_WR,
  output logic                   O_ARRAY_ERASE,
  output qpe_pkg::qpe_size_t     O_ERASE_SIZE,
  output logic [23:0]            O_ARRAY_ADDR,
  output logic [7:0]             O_ARRAY_WDATA
);
  import qpe_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic       cs_s1, cs_s2, cs_d;   // Select, two stages plus history
  logic       sck_s1, sck_s2, sck_d; // Link clock, sampled like data
  logic [3:0] io_s1, io_s2;         // Quad data lines

  // Link clock is slow against the core clock, so sampling suffices
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      {cs_s1, cs_s2, cs_d}    <= 3'h7; // Idle deselected, so no false select edge
      {sck_s1, sck_s2, sck_d} <= 3'h0; // Link clock parks low
      {io_s1, io_s2}          <= 8'h00;
    end
    else
    begin
      {cs_s1, cs_s2, cs_d}    <= {I_CS_N, cs_s1, cs_s2};
      {sck_s1, sck_s2, sck_d} <= {I_SCK, sck_s1, sck_s2};
      {io_s1, io_s2}          <= {I_IO, io_s1};
    end
  end

  logic sck_rise, cs_fall, cs_rise; // Edge events on synced pins
  assign sck_rise = sck_s2 & ~sck_d & ~cs_s2;
  assign cs_fall  = cs_d & ~cs_s2;
  assign cs_rise  = ~cs_d & cs_s2;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state
  qpe_state_t  state, next_state;
  qpe_size_t   esize, next_esize;
  logic        frame_ok, next_frame_ok;   // Frame began while idle
  logic [7:0]  opcode, next_opcode;
  logic [23:0] addr, next_addr;           // byte_address_field
  logic [5:0]  bits, next_bits;           // Header bits received
  logic [2:0]  sub, next_sub;             // Bits beyond header, mod 8
  logic        half, next_half;           // Upper nibble held
  logic [3:0]  nib, next_nib;
  logic [8:0]  byte_cnt, next_byte_cnt;   // Low bits index, bit 8 marks a full page
  logic [255:0] valid, next_valid;        // Page slots holding data
  logic [8:0]  walk, next_walk;
  logic        pend, next_pend;           // Write due this cycle
  logic [31:0] timer, next_timer;
  logic        write_latch_flag, next_wel;             // write_latch_flag
  logic        program_erase_error_flag, next_epe;             // program_erase_error_flag
  logic        erase_p, next_erase_p;
  logic [23:0] aaddr, next_aaddr;
  logic        buf_we;
  logic [7:0]  buf_wa, buf_wd, buf_rd;
  logic [23:0] emask;
  logic        is_prog, is_erase, prog_ok, erase_ok;

  assign is_prog  = (opcode == `QPE_OP_QPROG);
  assign is_erase = (opcode == `QPE_OP_ERASE4K) || (opcode == `QPE_OP_ERASE32K)
                  || (opcode == `QPE_OP_ERASE64K);
  // Whole header, a whole data byte, release between bytes
  assign prog_ok  = (bits == `QPE_HDR_BITS) && (byte_cnt != 9'h000) && !half;
  assign erase_ok = (bits == `QPE_HDR_BITS) && (sub == 3'h0);

  // Block-local bits dropped from the erase address
  always_comb
  begin
    unique case (esize)
      SZ_4K:   emask = `QPE_MASK_4K;
      SZ_32K:  emask = `QPE_MASK_32K;
      SZ_64K:  emask = `QPE_MASK_64K;
      default: emask = `QPE_MASK_64K; // Code 11 never loaded
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    next_state    = state;
    next_esize    = esize;
    {next_frame_ok, next_half, next_wel, next_epe} = {frame_ok, half, write_latch_flag, program_erase_error_flag};
    {next_opcode, next_bits, next_sub, next_nib}   = {opcode, bits, sub, nib};
    {next_addr, next_aaddr, next_walk}             = {addr, aaddr, walk};
    {next_byte_cnt, next_timer}                    = {byte_cnt, timer};
    next_valid    = valid;
    {next_pend, next_erase_p}                      = 2'h0; // Pulses last one cycle
    buf_we        = 1'b0;
    buf_wa        = addr[7:0] + byte_cnt[7:0];
    buf_wd        = {nib, io_s2};
    // Frame start: clear counters; frames begun while busy are ignored
    if (cs_fall)
    begin
      next_frame_ok = (state == ST_IDLE);
      next_opcode   = 8'h00;
      next_bits     = 6'h00;
      next_sub      = 3'h0;
      next_half     = 1'b0;
      next_byte_cnt = 9'h000;
      if (state == ST_IDLE)
      begin
        next_valid = '0;
      end
    end
    unique case (state)
      ST_IDLE:
      begin
        if (sck_rise && frame_ok)
        begin
          if (bits < `QPE_HDR_BITS)
          begin
            // Opcode then address, one bit per clock on line 0
            next_bits = bits + 6'h01;
            if (bits < `QPE_OPC_BITS)
            begin
              next_opcode = {opcode[6:0], io_s2[0]};
            end
            else
            begin
              next_addr = {addr[22:0], io_s2[0]};
            end
          end
          else if (is_prog)
          begin
            if (!half)
            begin
              next_nib  = io_s2; // Line 3 carries bit 7
              next_half = 1'b1;
            end
            else
            begin
              // Wrapped index overwrites, so only the last page stays
              buf_we             = 1'b1;
              next_valid[buf_wa] = 1'b1;
              next_half          = 1'b0;
              // Index keeps wrapping so byte 257 lands one past byte 256
              next_byte_cnt      = {byte_cnt[8] | (&byte_cnt[7:0]), byte_cnt[7:0] + 8'h01};
            end
          end
          else
          begin
            next_sub = sub + 3'h1; // Trailing bits ignored
          end
        end
        if (cs_rise && frame_ok && write_latch_flag && (is_prog || is_erase))
        begin
          next_frame_ok = 1'b0;
          next_wel      = 1'b0;
          if ((is_prog ? prog_ok : erase_ok) && !I_ADDR_PROTECTED)
          begin
            next_epe   = 1'b0;
            next_walk  = 9'h000;
            next_state = is_prog ? ST_PROG : ST_ERASE;
            next_esize = (opcode == `QPE_OP_ERASE4K)  ? SZ_4K  :
                         (opcode == `QPE_OP_ERASE32K) ? SZ_32K : SZ_64K;
          end
        end
      end
      ST_PROG:
      begin
        // Visit every page slot; only received slots are written
        if (walk == `QPE_PAGE_END)
        begin
          next_timer = 32'(PP_CYCLES);
          next_state = ST_WAIT;
        end
        else
        begin
          next_pend  = valid[walk[7:0]]; // Others keep erased value
          next_aaddr = {addr[23:8], walk[7:0]};
          next_walk  = walk + 9'h001;
        end
      end
      ST_ERASE:
      begin
        next_erase_p = 1'b1;
        next_aaddr   = addr & ~emask;
        next_timer   = 32'(BE_CYCLES);
        next_state   = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (timer == 32'h0000_0000)
        begin
          next_epe   = I_VERIFY_FAIL;
          next_state = ST_IDLE;
        end
        else
        begin
          next_timer = timer - 32'h0000_0001;
        end
      end
    endcase
    // Write enable outranks an abort's clear; a starting command keeps it cleared
    if (I_WRITE_ENABLE && (state == ST_IDLE) && (next_state == ST_IDLE))
    begin
      next_wel = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      state    <= ST_IDLE;
      esize    <= SZ_4K;
      {frame_ok, half, pend, write_latch_flag, program_erase_error_flag, erase_p} <= 6'h00;
      {opcode, bits, sub, nib}                  <= 21'h000000;
      {addr, aaddr, walk}                       <= 57'h0;
      {byte_cnt, timer}                         <= 41'h0;
      valid    <= '0;
    end
    else
    begin
      state    <= next_state;
      esize    <= next_esize;
      {frame_ok, half, pend, write_latch_flag} <= {next_frame_ok, next_half, next_pend, next_wel};
      {program_erase_error_flag, erase_p, opcode}      <= {next_epe, next_erase_p, next_opcode};
      {bits, sub, nib}            <= {next_bits, next_sub, next_nib};
      {addr, aaddr, walk}         <= {next_addr, next_aaddr, next_walk};
      {byte_cnt, timer}           <= {next_byte_cnt, next_timer};
      valid    <= next_valid;
    end
  end

  // Page buffer; read data lines up with the registered write pulse
  qpe_page_buf u_buf (
    .i_clk     (I_CLK),
    .i_wr_en   (buf_we),
    .i_wr_addr (buf_wa),
    .i_wr_data (buf_wd),
    .i_rd_addr (walk[7:0]),
    .o_rd_data (buf_rd)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign O_BUSY        = (state != ST_IDLE);
  assign O_WRITE_LATCH = write_latch_flag;
  assign O_PE_ERROR    = program_erase_error_flag;
  assign O_CHECK_ADDR  = addr;
  assign O_ARRAY_WR    = pend;
  assign O_ARRAY_ERASE = erase_p;
  assign O_ERASE_SIZE  = esize;
  assign O_ARRAY_ADDR  = aaddr;
  assign O_ARRAY_WDATA = pend ? buf_rd : `QPE_ERASED;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  chk_prog_needs_wel: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (state == ST_IDLE) && (next_state == ST_PROG) |-> write_latch_flag && is_prog)
    else $error("program started without write latch");
  chk_erase_needs_wel: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (state == ST_IDLE) && (next_state == ST_ERASE) |-> write_latch_flag && is_erase)
    else $error("erase started without write latch");
  chk_prog_complete: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (state == ST_IDLE) ##1 (state == ST_PROG) |-> $past(prog_ok) && ($past(bits) == 6'h20))
    else $error("program started on incomplete frame");
  chk_erase_boundary: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    $rose(erase_p) |-> $past(sub, 2) == 3'h0)
    else $error("erase started off byte boundary");
  chk_protect_idle: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    cs_rise && I_ADDR_PROTECTED && frame_ok && (is_prog || is_erase) && !I_WRITE_ENABLE
    |=> (state == ST_IDLE) && !write_latch_flag)
    else $error("protected target not refused");
  chk_wel_clear: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    cs_rise && frame_ok && write_latch_flag && (is_prog || is_erase) && !I_WRITE_ENABLE |=> !write_latch_flag)
    else $error("write latch kept after command");
  chk_busy_no_wel: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    O_BUSY && !$rose(O_BUSY) |-> !write_latch_flag)
    else $error("write latch set while busy");
  chk_erase_align: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    erase_p |-> ((aaddr & emask) == 24'h000000) && (state == ST_WAIT))
    else $error("erase address not block aligned");
  chk_wr_in_page: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    pend |-> (aaddr[23:8] == addr[23:8]) && O_BUSY)
    else $error("program write left the page");
  chk_nibble_pair: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    buf_we |-> half ##1 !half)
    else $error("byte assembled without two nibbles");
  chk_epe_update: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (state == ST_WAIT) && (timer == 32'h0) |=> (program_erase_error_flag == $past(I_VERIFY_FAIL)) && !O_BUSY)
    else $error("error flag not taken at completion");

endmodule : qpe_seq

// file: testbench/qpe_host_model.sv
`timescale 1ns/1ps
`include "qpe_regs.svh"
////////////////////////////////////////////////////////////////////////
// Host side of the link: select, link clock and quad lines
module qpe_host_model (
  output logic       o_cs_n,
  output logic       o_sck,
  output logic [3:0] o_io
);
  logic [7:0] dat [0:511]; // Bytes for the data phase

  // Link idles deselected with the clock parked low
  initial
  begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_io   = 4'h0;
  end

  // One link clock, lines set up half a period before the rise
  task automatic clk_io(input logic [3:0] v);
    o_io = v;
    #100 o_sck = 1'b1;
    #100 o_sck = 1'b0;
  endtask : clk_io

  // Frame: opcode, abits address bits, whole bytes, stray nibbles
  task automatic frame(input logic [7:0] opc, input logic [23:0] adr,
                       input int abits, input int nbytes, input int nibs);
    o_cs_n = 1'b0;
    #100;
    for (int i = 7; i >= 0; i--)
      clk_io({{3{~opc[i]}}, opc[i]});
    for (int i = 0; i < abits; i++)
      clk_io({{3{~adr[23-i]}}, adr[23-i]});
    for (int k = 0; k < nbytes; k++)
    begin
      if (opc == `QPE_OP_QPROG)
      begin
        clk_io(dat[k][7:4]);
        clk_io(dat[k][3:0]);
      end
      else
        for (int i = 7; i >= 0; i--)
          clk_io({3'h0, dat[k][i]}); // Erase extras are plain serial bytes
    end
    for (int k = 0; k < nibs; k++)
      clk_io(4'h5); // Half byte leaves select off a boundary
    #100 o_cs_n = 1'b1;
    // Released lines must not keep showing the last nibble
    o_io = ~o_io;
  endtask : frame
endmodule : qpe_host_model

// file: testbench/qpe_seq_bench.sv
`timescale 1ns/1ps
`include "qpe_regs.svh"
////////////////////////////////////////////////////////////////////////
// Self-checking bench for the program and erase sequencer
module qpe_seq_bench;
  import qpe_pkg::*;
  localparam int PP = 20; // Short program time keeps the run brief
  localparam int BE = 30; // Short erase time likewise

  logic        I_CLK, I_RSTN, I_CS_N, I_SCK;
  logic [3:0]  I_IO;
  logic        I_WRITE_ENABLE, I_ADDR_PROTECTED, I_VERIFY_FAIL;
  logic        O_BUSY, O_WRITE_LATCH, O_PE_ERROR, O_ARRAY_WR, O_ARRAY_ERASE;
  logic [23:0] O_CHECK_ADDR, O_ARRAY_ADDR, er_addr;
  logic [7:0]  O_ARRAY_WDATA;
  qpe_size_t   O_ERASE_SIZE, er_size;
  logic [7:0]  got [0:255];   // Bytes written this command
  logic [7:0]  exp_pg [0:255];
  logic [15:0] exp_hi;         // Page expected on every write
  int          n_fail, n_compared, n_wr, n_er, bad_hi, busy_seen, cyc, bad;
  logic [7:0]  ops [3] = '{`QPE_OP_ERASE4K, `QPE_OP_ERASE32K, `QPE_OP_ERASE64K};
  logic [23:0] msk [3] = '{`QPE_MASK_4K, `QPE_MASK_32K, `QPE_MASK_64K};
  qpe_size_t   szs [3] = '{SZ_4K, SZ_32K, SZ_64K};

  qpe_seq #(.PP_CYCLES(PP), .BE_CYCLES(BE)) DUT (
    .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_CS_N(I_CS_N), .I_SCK(I_SCK), .I_IO(I_IO),
    .I_WRITE_ENABLE(I_WRITE_ENABLE), .I_ADDR_PROTECTED(I_ADDR_PROTECTED),
    .I_VERIFY_FAIL(I_VERIFY_FAIL), .O_BUSY(O_BUSY), .O_WRITE_LATCH(O_WRITE_LATCH),
    .O_PE_ERROR(O_PE_ERROR), .O_CHECK_ADDR(O_CHECK_ADDR), .O_ARRAY_WR(O_ARRAY_WR),
    .O_ARRAY_ERASE(O_ARRAY_ERASE), .O_ERASE_SIZE(O_ERASE_SIZE),
    .O_ARRAY_ADDR(O_ARRAY_ADDR), .O_ARRAY_WDATA(O_ARRAY_WDATA)
  );
  qpe_host_model host (.o_cs_n(I_CS_N), .o_sck(I_SCK), .o_io(I_IO));

  // Core clock, 25 ns period
  initial
  begin
    I_CLK = 1'b0;
    forever #12.5 I_CLK = ~I_CLK;
  end

  ////////////////////////////////////////////////////////////////////////
  // Array-side monitor and hang guard
  always @(posedge I_CLK)
  begin
    cyc++;
    if (O_BUSY === 1'b1)
      busy_seen++;
    if (O_ARRAY_WR === 1'b1)
    begin
      n_wr++;
      got[O_ARRAY_ADDR[7:0]] = O_ARRAY_WDATA;
      if (O_ARRAY_ADDR[23:8] !== exp_hi)
        bad_hi++; // Write left the addressed page
    end
    if (O_ARRAY_ERASE === 1'b1)
    begin
      n_er++;
      er_addr = O_ARRAY_ADDR;
      er_size = O_ERASE_SIZE;
    end
    if (cyc > 40000)
    begin
      n_fail++; // Ceiling is several times the expected run
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared compare, command and verdict tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Latch set or not, then one frame, then bounded poll for idle
  task automatic run(input logic [7:0] opc, input logic [23:0] adr, input int abits,
                     input int nbytes, input int nibs, input logic we, input logic prot,
                     input logic vf);
    @(posedge I_CLK);
    I_WRITE_ENABLE   <= we;
    I_ADDR_PROTECTED <= prot;
    I_VERIFY_FAIL    <= vf;
    @(posedge I_CLK);
    I_WRITE_ENABLE <= 1'b0;
    n_wr      = 0;
    n_er      = 0;
    bad_hi    = 0;
    busy_seen = 0;
    exp_hi    = adr[23:8];
    for (int i = 0; i < 256; i++)
      got[i] = 8'hFF;
    @(posedge I_CLK);
    #1;
    chk("latch_before", {31'h0, we}, {31'h0, O_WRITE_LATCH});
    host.frame(opc, adr, abits, nbytes, nibs);
    repeat (10) @(posedge I_CLK);
    #1;
    if (O_BUSY === 1'b1)
      chk("latch_busy", 32'h0, {31'h0, O_WRITE_LATCH});
    for (int t = 0; t < 2000 && O_BUSY !== 1'b0; t++)
      @(posedge I_CLK);
    #1;
    chk("idle_end", 32'h0, {31'h0, O_BUSY});
  endtask : run

  // Aborted or skipped command: no activity, latch dropped
  task automatic refused(input string nm);
    chk({nm, "_busy"}, 32'h0, busy_seen);
    chk({nm, "_acts"}, 32'h0, n_wr + n_er);
    chk({nm, "_latch"}, 32'h0, {31'h0, O_WRITE_LATCH});
  endtask : refused

  // Page image from start offset and byte count, last write wins
  task automatic page_chk(input logic [7:0] st, input int n);
    bad = 0;
    for (int i = 0; i < 256; i++)
      exp_pg[i] = `QPE_ERASED;
    for (int k = 0; k < n; k++)
      exp_pg[8'(st + k)] = host.dat[k];
    for (int i = 0; i < 256; i++)
      if (got[i] !== exp_pg[i])
        bad++;
    chk("page_bad", 32'h0, bad);
    chk("page_wr", (n > 256) ? 256 : n, n_wr);
    chk("page_hi", 32'h0, bad_hi);
  endtask : page_chk

  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    I_RSTN           = 1'b0;
    I_WRITE_ENABLE   = 1'b0;
    I_ADDR_PROTECTED = 1'b0;
    I_VERIFY_FAIL    = 1'b0;
    for (int k = 0; k < 512; k++)
      host.dat[k] = 8'(k) ^ 8'h5A;
    repeat (2) @(posedge I_CLK);
    I_RSTN <= 1'b1;
    repeat (3) @(posedge I_CLK);
    // Program with latch clear does nothing
    run(`QPE_OP_QPROG, 24'h0000FE, 24, 3, 0, 1'b0, 1'b0, 1'b0);
    refused("no_latch");
    // Wrap past page end, verify failure reported
    run(`QPE_OP_QPROG, 24'h0000FE, 24, 3, 0, 1'b1, 1'b0, 1'b1);
    chk("prog_busy", 32'h1, {31'h0, busy_seen != 0});
    page_chk(8'hFE, 3);
    chk("prog_err", 32'h1, {31'h0, O_PE_ERROR});
    chk("prog_latch", 32'h0, {31'h0, O_WRITE_LATCH});
    // Overlong page keeps the last 256 bytes, error flag cleared
    run(`QPE_OP_QPROG, 24'h012300, 24, 258, 0, 1'b1, 1'b0, 1'b0);
    page_chk(8'h00, 258);
    chk("prog_err_clr", 32'h0, {31'h0, O_PE_ERROR});
    // Half data byte, short address, protected target
    run(`QPE_OP_QPROG, 24'h000010, 24, 1, 1, 1'b1, 1'b0, 1'b0);
    refused("half_byte");
    run(`QPE_OP_QPROG, 24'h000010, 16, 0, 0, 1'b1, 1'b0, 1'b0);
    refused("short_adr");
    run(`QPE_OP_QPROG, 24'h000010, 24, 2, 0, 1'b1, 1'b1, 1'b0);
    refused("prot_prog");
    // Every erase size, extra bytes ignored, low bits masked
    for (int i = 0; i < 3; i++)
    begin
      run(ops[i], 24'h123456, 24, i, 0, 1'b1, 1'b0, i == 2);
      chk("er_count", 32'h1, n_er);
      chk("chk_addr", {8'h0, 24'h123456}, {8'h0, O_CHECK_ADDR});
      chk("er_addr", {8'h0, 24'h123456 & ~msk[i]}, {8'h0, er_addr});
      chk("er_size", {30'h0, szs[i]}, {30'h0, er_size});
      chk("er_err", {31'h0, i == 2}, {31'h0, O_PE_ERROR});
      chk("er_latch", 32'h0, {31'h0, O_WRITE_LATCH});
    end
    // Erase aborts and protected erase
    run(`QPE_OP_ERASE4K, 24'h123456, 16, 0, 0, 1'b1, 1'b0, 1'b0);
    refused("er_short");
    run(`QPE_OP_ERASE32K, 24'h123456, 24, 0, 1, 1'b1, 1'b0, 1'b0);
    refused("er_half");
    run(`QPE_OP_ERASE64K, 24'h123456, 24, 0, 0, 1'b1, 1'b1, 1'b0);
    refused("er_prot");
    close_out();
  end
endmodule : qpe_seq_bench
